// ### hw/cfm_consts.vh
// Offsets, field positions and reset values of the fault mask bank
`ifndef CFM_CONSTS_VH
`define CFM_CONSTS_VH
`define CFM_ADDR_W 8
`define CFM_DATA_W 8
`define CFM_OFS_HOST_TX_MASK 8'h0B
`define CFM_OFS_UP_PORT_MASK 8'h0C
`define CFM_OFS_UP_RX_CMD_MASK 8'h0D
`define CFM_OFS_IRQ_STATUS 8'h20
`define CFM_OFS_IRQ_MASK 8'h21
`define CFM_MASK_RESET 8'h00
`define CFM_HTX_HOLD_OFF_BIT 0
`define CFM_HTX_FRAME_START_BIT 1
`define CFM_HTX_FAULTS 2
`define CFM_UP_FAULTS 6
`define CFM_RXC_FAULTS 6
`define CFM_IRQ_HTX_BIT 0
`define CFM_IRQ_UP_BIT 1
`define CFM_IRQ_RXC_BIT 2
`define CFM_IRQ_BITS 3
`endif

// ### hw/cfm_mask_reg.v
// One read/write mask register with its fault gate
`timescale 1ns/100ps
`include "cfm_consts.vh"
module cfm_mask_reg #(
  parameter [7:0] OFS = 8'h00,
  parameter NF = 6
) (
  // Clock and reset
  input wire i_clk,
  input wire i_nrst,
  // Register port
  input wire [7:0] i_addr,
  input wire [7:0] i_wdata,
  input wire i_wr,
  // Faults and stored mask
  input wire [NF-1:0] i_fault,
  output wire [7:0] o_mask,
  output wire [NF-1:0] o_fault
);
  reg [7:0] mask_r;
  always @(posedge i_clk) begin
    if (!i_nrst) begin
      mask_r <= `CFM_MASK_RESET;
    end else if (i_wr && i_addr == OFS) begin
      mask_r <= i_wdata;
    end
  end
  // Spare bits above NF are stored but gate nothing
  assign o_fault = i_fault & ~mask_r[NF-1:0];
  assign o_mask = mask_r;
endmodule

// ### hw/cfm_irq.v
// Sticky event status, mask and level interrupt
`timescale 1ns/100ps
`include "cfm_consts.vh"
module cfm_irq #(
  parameter N = 3
) (
  // Clock and reset
  input wire i_clk,
  input wire i_nrst,
  // Events and software access
  input wire [N-1:0] i_evt,
  input wire i_clr_wr,
  input wire i_msk_wr,
  input wire [N-1:0] i_wdata,
  output wire [N-1:0] o_status,
  output wire [N-1:0] o_mask,
  output wire o_irq
);
  reg [N-1:0] status_r;
  reg [N-1:0] mask_r;
  always @(posedge i_clk) begin
    if (!i_nrst) begin
      status_r <= {N{1'b0}};
      mask_r <= {N{1'b0}};
    end else begin
      // A new event wins over a clear in the same cycle
      status_r <= (status_r & ~(i_clr_wr ? i_wdata : {N{1'b0}})) | i_evt;
      if (i_msk_wr) begin
        mask_r <= i_wdata;
      end
    end
  end
  assign o_status = status_r;
  assign o_mask = mask_r;
  assign o_irq = |(status_r & mask_r);
endmodule

// ### hw/cfm_top.v
// Communication fault mask register bank
`timescale 1ns/100ps
`include "cfm_consts.vh"
module cfm_top (
  // Clock and reset
  input wire i_clk,
  input wire i_nrst,
  // Register port
  input wire [`CFM_ADDR_W-1:0] i_addr,
  input wire [`CFM_DATA_W-1:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  output reg [`CFM_DATA_W-1:0] o_rdata,
  // Raw faults
  input wire [`CFM_HTX_FAULTS-1:0] i_host_tx_fault,
  input wire [`CFM_UP_FAULTS-1:0] i_up_port_fault,
  input wire [`CFM_RXC_FAULTS-1:0] i_up_rx_cmd_fault,
  // Signalled faults
  output wire [`CFM_HTX_FAULTS-1:0] o_host_tx_fault,
  output wire [`CFM_UP_FAULTS-1:0] o_up_port_fault,
  output wire [`CFM_RXC_FAULTS-1:0] o_up_rx_cmd_fault,
  // Interrupt
  output wire o_irq
);
  wire [7:0] htx_mask;
  wire [7:0] up_mask;
  wire [7:0] rxc_mask;
  wire [`CFM_IRQ_BITS-1:0] irq_status;
  wire [`CFM_IRQ_BITS-1:0] irq_mask;
  wire [`CFM_IRQ_BITS-1:0] evt;

  // Bit 1 frame-start error, bit 0 hold-off
  cfm_mask_reg #(.OFS(`CFM_OFS_HOST_TX_MASK), .NF(`CFM_HTX_FAULTS)) u_htx (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .i_addr(i_addr),
    .i_wdata(i_wdata),
    .i_wr(i_wr),
    .i_fault(i_host_tx_fault),
    .o_mask(htx_mask),
    .o_fault(o_host_tx_fault)
  );

  // Bits 5..0: byte, missed word, sequence, align2, align1, pulse level
  cfm_mask_reg #(.OFS(`CFM_OFS_UP_PORT_MASK), .NF(`CFM_UP_FAULTS)) u_up (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .i_addr(i_addr),
    .i_wdata(i_wdata),
    .i_wr(i_wr),
    .i_fault(i_up_port_fault),
    .o_mask(up_mask),
    .o_fault(o_up_port_fault)
  );

  // Bits 5..0: internal, tx disabled, frame start, byte, surprise, checksum
  cfm_mask_reg #(.OFS(`CFM_OFS_UP_RX_CMD_MASK), .NF(`CFM_RXC_FAULTS)) u_rxc (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .i_addr(i_addr),
    .i_wdata(i_wdata),
    .i_wr(i_wr),
    .i_fault(i_up_rx_cmd_fault),
    .o_mask(rxc_mask),
    .o_fault(o_up_rx_cmd_fault)
  );

  // Only faults that survive the masks raise events
  assign evt[`CFM_IRQ_HTX_BIT] = |o_host_tx_fault;
  assign evt[`CFM_IRQ_UP_BIT] = |o_up_port_fault;
  assign evt[`CFM_IRQ_RXC_BIT] = |o_up_rx_cmd_fault;

  cfm_irq #(.N(`CFM_IRQ_BITS)) u_irq (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .i_evt(evt),
    .i_clr_wr(i_wr && i_addr == `CFM_OFS_IRQ_STATUS),
    .i_msk_wr(i_wr && i_addr == `CFM_OFS_IRQ_MASK),
    .i_wdata(i_wdata[`CFM_IRQ_BITS-1:0]),
    .o_status(irq_status),
    .o_mask(irq_mask),
    .o_irq(o_irq)
  );

  // Read data stands only in the cycle after the strobe; unmapped reads zero
  always @(posedge i_clk) begin
    if (!i_nrst) begin
      o_rdata <= 8'h00;
    end else if (i_rd) begin
      case (i_addr)
        `CFM_OFS_HOST_TX_MASK: o_rdata <= htx_mask;
        `CFM_OFS_UP_PORT_MASK: o_rdata <= up_mask;
        `CFM_OFS_UP_RX_CMD_MASK: o_rdata <= rxc_mask;
        `CFM_OFS_IRQ_STATUS: o_rdata <= {5'h00, irq_status};
        `CFM_OFS_IRQ_MASK: o_rdata <= {5'h00, irq_mask};
        default: o_rdata <= 8'h00;
      endcase
    end else begin
      o_rdata <= 8'h00;
    end
  end
endmodule

// ### sim/cfm_chk.sv
// Port assertions for the fault mask bank
`timescale 1ns/100ps
module cfm_chk (
  // Clock, reset, register port
  input wire i_clk,
  input wire i_nrst,
  input wire [7:0] i_addr,
  input wire [7:0] i_wdata,
  input wire i_wr,
  input wire [7:0] o_rdata,
  // Faults
  input wire [1:0] i_host_tx_fault,
  input wire [1:0] o_host_tx_fault,
  input wire [5:0] i_up_port_fault,
  input wire [5:0] o_up_port_fault,
  input wire [5:0] i_up_rx_cmd_fault,
  input wire [5:0] o_up_rx_cmd_fault
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_nrst);
  htx_gate_a: assert property (
    i_wr && i_addr == 8'h0B |=> o_host_tx_fault == (i_host_tx_fault & ~$past(i_wdata[1:0])))
    else $error("host mask");
  frame_start_a: assert property (
    i_wr && i_addr == 8'h0B && i_wdata[1] |=> !o_host_tx_fault[1]) else $error("sof");
  up_gate_a: assert property (
    i_wr && i_addr == 8'h0C |=> o_up_port_fault == (i_up_port_fault & ~$past(i_wdata[5:0])))
    else $error("up mask");
  align_pass_a: assert property (
    i_wr && i_addr == 8'h0C && !i_wdata[1] |=> o_up_port_fault[1] == i_up_port_fault[1])
    else $error("align");
  rxc_gate_a: assert property (
    i_wr && i_addr == 8'h0D |=> o_up_rx_cmd_fault == (i_up_rx_cmd_fault & ~$past(i_wdata[5:0])))
    else $error("rx mask");
  reset_clear_a: assert property (
    $rose(i_nrst) |-> o_up_rx_cmd_fault == i_up_rx_cmd_fault) else $error("reset");
endmodule
bind cfm_top cfm_chk u_chk (.i_clk, .i_nrst, .i_addr, .i_wdata, .i_wr, .o_rdata,
  .i_host_tx_fault, .o_host_tx_fault, .i_up_port_fault, .o_up_port_fault,
  .i_up_rx_cmd_fault, .o_up_rx_cmd_fault);

// ### sim/cfm_top_tb_top.sv
// Random self-checking bench for the fault mask bank
`timescale 1ns/100ps
module cfm_top_tb_top;
  logic i_clk = 0, i_nrst = 0, i_wr = 0, i_rd = 0, rd_q = 0, o_irq;
  logic [7:0] i_addr = '0, i_wdata = '0, o_rdata, a;
  logic [1:0] i_host_tx_fault = '0, o_host_tx_fault;
  logic [5:0] i_up_port_fault = '0, o_up_port_fault, i_up_rx_cmd_fault = '0, o_up_rx_cmd_fault;
  logic [7:0] m [0:4];
  logic [13:0] fq [$];
  logic [7:0] rq [$];
  logic [31:0] r;
  int err_total = 0, n_tests = 0, seed = 89;
  cfm_top u_dut (.i_clk, .i_nrst, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .i_host_tx_fault,
    .i_up_port_fault, .i_up_rx_cmd_fault, .o_host_tx_fault, .o_up_port_fault,
    .o_up_rx_cmd_fault, .o_irq);
  initial forever #5 i_clk = ~i_clk;
  task chk(input logic [13:0] e, input logic [13:0] g);
    n_tests++;
    if (g !== e) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task chk_rd(input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task chk_irq(input logic e, input logic g);
    n_tests++;
    if (g !== e) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // One bus cycle; notes the expected faults, and the read data when reading
  task step(input logic w, input logic rd, input logic [7:0] ad, input logic [7:0] d,
    input logic [13:0] f, input logic [7:0] er);
    @(posedge i_clk);
    i_addr <= ad;
    i_wdata <= d;
    i_wr <= w;
    i_rd <= rd;
    {i_host_tx_fault, i_up_port_fault, i_up_rx_cmd_fault} <= f;
    fq.push_back(f & ~{m[1][1:0], m[2][5:0], m[3][5:0]});
    if (rd) rq.push_back(er);
    if (w && ad > 8'h0A && ad < 8'h0E) m[ad - 10] = d;
  endtask
  task final_report;
    $display("checks %0d errors %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  always @(posedge i_clk) rd_q <= i_rd;
  always @(negedge i_clk) begin
    if (fq.size() > 0) chk(fq.pop_front(), {o_host_tx_fault, o_up_port_fault, o_up_rx_cmd_fault});
    if (rd_q) chk_rd(rq.pop_front(), o_rdata);
  end
  initial begin
    #20000;
    err_total++;
    final_report;
  end
  initial begin
    for (int k = 0; k < 5; k++) m[k] = '0;
    repeat (5) @(posedge i_clk);
    i_nrst <= 1;
    // Unmapped 0x0A and 0x0E mixed in; their reads must give zero
    repeat (600) begin
      r = $random(seed);
      a = 8'h0A + r[10:8] % 5;
      step(r[1:0] == 2'h1, r[1:0] == 2'h2, a, r[23:16], r[31:18], m[a - 10]);
    end
    // Interrupt path: clear sticky status, unmask one source, raise one fault
    step(1'b1, 1'b0, 8'h0C, 8'h00, 14'h0000, 8'h00);
    step(1'b1, 1'b0, 8'h20, 8'h07, 14'h0000, 8'h00);
    step(1'b1, 1'b0, 8'h21, 8'h02, 14'h0040, 8'h00);
    @(negedge i_clk);
    chk_irq(1'b0, o_irq);
    step(1'b0, 1'b1, 8'h20, 8'h00, 14'h0000, 8'h02);
    @(negedge i_clk);
    chk_irq(1'b1, o_irq);
    // Mid-run reset must clear every mask and the interrupt
    step(1'b0, 1'b0, 8'h00, 8'h00, 14'h0000, 8'h00);
    @(posedge i_clk);
    i_nrst <= 0;
    for (int k = 0; k < 5; k++) m[k] = '0;
    repeat (2) @(posedge i_clk);
    i_nrst <= 1;
    step(1'b0, 1'b1, 8'h0C, 8'h00, 14'h3FFF, 8'h00);
    step(1'b0, 1'b1, 8'h0B, 8'h00, 14'h3FFF, 8'h00);
    @(negedge i_clk);
    chk_irq(1'b0, o_irq);
    step(1'b0, 1'b0, 8'h00, 8'h00, 14'h0000, 8'h00);
    repeat (2) @(negedge i_clk);
    final_report;
  end
endmodule
